// ===== rtl/serial_baud_rate_generator.sv
// Purpose: baud rate generator of the async serial unit, apb slave
// Assumes: pclk 100 MHz, presetn asynchronous active low
// Notes: rate outputs are one-cycle enables, not clocks
// Summary of operation
// - first prescaler divides by 1, 3, 4, 13
// - conventional tx rate: prescaler times 2^n
// - conventional rx rate: prescaler times 2^n, independent
// - nonzero rx extended factor divides sixteenth clock
// - nonzero tx extended factor divides sixteenth clock
// - separate extended factors, both zero after reset
// - power down halts dividers after current byte
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
module serial_baud_rate_generator (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic byte_busy,
  input wire logic [7:0] status_in,
  input wire logic [7:0] rx_data_in,
  output logic tx_tick,
  output logic rx_tick,
  output logic data_wr_pulse,
  output logic [7:0] tx_data,
  output logic [7:0] control_one,
  output logic [7:0] control_two,
  output logic halted
);
  // ***********************************
  // register file
  // ***********************************
  logic [7:0] ext_rx_prescaler_ff; // extended rx factor
  logic [7:0] ext_tx_prescaler_ff; // extended tx factor
  logic [7:0] baud_rate_select_ff; // prescaler and divisor codes
  logic [7:0] serial_control_one_ff; // holds power-down bit
  logic [7:0] serial_control_two_ff; // passed to the serial unit
  logic [7:0] tx_data_ff; // last written data byte
  logic data_wr_ff; // data write strobe
  logic [31:0] prdata_ff; // registered read data
  logic pready_ff; // registered ready
  logic pslverr_ff; // registered error
  logic halted_ff; // prescalers stopped
  logic tx_tick_ff; // registered tx enable
  logic rx_tick_ff; // registered rx enable
  logic restart_ff; // divisor register written last cycle

  logic setup; // setup phase of a transfer
  logic [9:0] addr; // word-aligned byte address
  logic wr_ok; // write with low byte lane enabled
  logic mapped; // address hits a register

  // decode of a byte address to a known register
  function automatic logic is_mapped(input logic [9:0] a);
    is_mapped = (a == baud_pkg::addr_ext_rx_prescaler) || (a == baud_pkg::addr_ext_tx_prescaler) ||
                (a == baud_pkg::addr_serial_status) || (a == baud_pkg::addr_serial_data) ||
                (a == baud_pkg::addr_baud_rate_select) || (a == baud_pkg::addr_serial_control_one) ||
                (a == baud_pkg::addr_serial_control_two);
  endfunction

  // accesses are taken in the setup cycle and answered one cycle later
  assign setup = psel && !penable;
  assign addr = {paddr[9:2], 2'b00};
  assign mapped = is_mapped(addr) && (paddr[31:10] == 22'h000000);
  assign wr_ok = setup && pwrite && mapped && pstrb[0];

  // ***********************************
  // apb handshake
  // ***********************************
  // zero wait states: ready rises in the access cycle
  // the write itself lands at the setup edge; the access cycle only reports it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !mapped; // unmapped address answers with an error
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
    end else if (setup && !pwrite) begin
      case (addr)
        baud_pkg::addr_ext_rx_prescaler: prdata_ff <= {24'h000000, ext_rx_prescaler_ff};
        baud_pkg::addr_ext_tx_prescaler: prdata_ff <= {24'h000000, ext_tx_prescaler_ff};
        baud_pkg::addr_serial_status: prdata_ff <= {24'h000000, status_in};
        baud_pkg::addr_serial_data: prdata_ff <= {24'h000000, rx_data_in};
        baud_pkg::addr_baud_rate_select: prdata_ff <= {24'h000000, baud_rate_select_ff};
        baud_pkg::addr_serial_control_one: prdata_ff <= {24'h000000, serial_control_one_ff};
        baud_pkg::addr_serial_control_two: prdata_ff <= {24'h000000, serial_control_two_ff};
        default: prdata_ff <= {24'h000000, baud_pkg::apb_unmapped_read};
      endcase
    end
  end

  // divisor registers; each write restarts the dividers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_rx_prescaler_ff <= baud_pkg::rst_ext_prescaler;
      ext_tx_prescaler_ff <= baud_pkg::rst_ext_prescaler;
      baud_rate_select_ff <= baud_pkg::rst_baud_rate_select;
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= 1'b0;
      if (wr_ok) begin
        case (addr)
          baud_pkg::addr_ext_rx_prescaler: begin
            ext_rx_prescaler_ff <= pwdata[7:0];
            restart_ff <= 1'b1;
          end
          baud_pkg::addr_ext_tx_prescaler: begin
            ext_tx_prescaler_ff <= pwdata[7:0];
            restart_ff <= 1'b1;
          end
          baud_pkg::addr_baud_rate_select: begin
            baud_rate_select_ff <= pwdata[7:0];
            restart_ff <= 1'b1;
          end
          default: restart_ff <= 1'b0;
        endcase
      end
    end
  end

  // control registers and the data byte for the transmitter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_control_one_ff <= baud_pkg::rst_serial_control;
      serial_control_two_ff <= baud_pkg::rst_serial_control;
      tx_data_ff <= 8'h00;
      data_wr_ff <= 1'b0;
    end else begin
      data_wr_ff <= wr_ok && (addr == baud_pkg::addr_serial_data);
      if (wr_ok && (addr == baud_pkg::addr_serial_control_one)) begin
        serial_control_one_ff <= pwdata[7:0];
      end
      if (wr_ok && (addr == baud_pkg::addr_serial_control_two)) begin
        serial_control_two_ff <= pwdata[7:0];
      end
      if (wr_ok && (addr == baud_pkg::addr_serial_data)) begin
        tx_data_ff <= pwdata[7:0];
      end
    end
  end

  // ***********************************
  // power down
  // ***********************************
  logic nxt_halted; // halt state after the coming edge

  // the stop waits for the byte in flight, so no frame is cut short
  always_comb begin
    if (!serial_control_one_ff[baud_pkg::serial_power_down_bit]) begin
      nxt_halted = 1'b0;
    end else if (!byte_busy) begin
      nxt_halted = 1'b1;
    end else begin
      nxt_halted = halted_ff; // a halt already taken holds while the bit stays set
    end
  end

  // the tick registers read nxt_halted too, so no tick leaks out on the stopping edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted_ff <= 1'b0;
    end else begin
      halted_ff <= nxt_halted;
    end
  end

  // ***********************************
  // divider chain
  // ***********************************
  logic [7:0] first_factor; // 1, 3, 4 or 13
  logic first_tick; // bus clock after the first prescaler
  logic [7:0] conv_taps; // power-of-two taps of the first-prescaler stream
  logic sixteenth_tick; // stream after the fixed divide-by-16
  logic ext_rx_tick; // extended receive rate
  logic ext_tx_tick; // extended transmit rate
  logic [2:0] tx_code; // transmit divisor code
  logic [2:0] rx_code; // receive divisor code
  logic run; // dividers advance

  assign run = !halted_ff;
  assign tx_code = baud_rate_select_ff[baud_pkg::tx_divisor_msb:baud_pkg::tx_divisor_lsb];
  assign rx_code = baud_rate_select_ff[baud_pkg::rx_divisor_msb:baud_pkg::rx_divisor_lsb];

  // prescaler code to factor
  always_comb begin
    case (baud_rate_select_ff[baud_pkg::first_prescale_msb:baud_pkg::first_prescale_lsb])
      2'b00: first_factor = {4'h0, baud_pkg::first_prescale_factor_0};
      2'b01: first_factor = {4'h0, baud_pkg::first_prescale_factor_1};
      2'b10: first_factor = {4'h0, baud_pkg::first_prescale_factor_2};
      2'b11: first_factor = {4'h0, baud_pkg::first_prescale_factor_3};
      default: first_factor = 8'h01;
    endcase
  end

  rate_divider first_div (
    .pclk(pclk),
    .presetn(presetn),
    .restart(restart_ff),
    .en_in(run),
    .divisor(first_factor),
    .tick(first_tick)
  );

  // power-of-two stage shared by both conventional paths
  stage_counter pow2 (
    .pclk(pclk),
    .presetn(presetn),
    .restart(restart_ff),
    .en_in(first_tick && run),
    .count(conv_taps)
  );

  // divide by 2^n: a pulse whenever the low n bits of the count wrap to zero
  // code zero gives an all-zero mask, so every first-stage pulse passes
  function automatic logic pow2_hit(input logic [7:0] taps, input logic [2:0] code);
    logic [7:0] mask;
    mask = 8'hff >> (4'h8 - {1'b0, code});
    pow2_hit = ((taps & mask) == 8'h00);
  endfunction

  // fixed divide-by-16 after the first prescaler feeds the extended paths
  rate_divider sixteen_div (
    .pclk(pclk),
    .presetn(presetn),
    .restart(restart_ff),
    .en_in(first_tick && run),
    .divisor({3'b000, baud_pkg::fixed_divide}),
    .tick(sixteenth_tick)
  );

  rate_divider ext_rx_div (
    .pclk(pclk),
    .presetn(presetn),
    .restart(restart_ff),
    .en_in(sixteenth_tick && run),
    .divisor(ext_rx_prescaler_ff),
    .tick(ext_rx_tick)
  );

  rate_divider ext_tx_div (
    .pclk(pclk),
    .presetn(presetn),
    .restart(restart_ff),
    .en_in(sixteenth_tick && run),
    .divisor(ext_tx_prescaler_ff),
    .tick(ext_tx_tick)
  );

  // ***********************************
  // rate selection
  // ***********************************
  // conventional taps act one pulse after the count lands, which keeps the output registered
  // a restart or a coming halt silences both outputs at that edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_tick_ff <= 1'b0;
      rx_tick_ff <= 1'b0;
    end else if (restart_ff || nxt_halted) begin
      tx_tick_ff <= 1'b0;
      rx_tick_ff <= 1'b0;
    end else begin
      if (ext_tx_prescaler_ff != 8'h00) begin
        tx_tick_ff <= ext_tx_tick;
      end else begin
        tx_tick_ff <= first_tick && pow2_hit(conv_taps, tx_code);
      end
      if (ext_rx_prescaler_ff != 8'h00) begin
        rx_tick_ff <= ext_rx_tick;
      end else begin
        rx_tick_ff <= first_tick && pow2_hit(conv_taps, rx_code);
      end
    end
  end

  // ***********************************
  // outputs
  // ***********************************
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign tx_tick = tx_tick_ff;
  assign rx_tick = rx_tick_ff;
  assign data_wr_pulse = data_wr_ff;
  assign tx_data = tx_data_ff;
  assign control_one = serial_control_one_ff;
  assign control_two = serial_control_two_ff;
  assign halted = halted_ff;
endmodule

// ===== rtl/baud_pkg.sv
// Purpose: shared constants for the serial baud rate generator
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: printed offsets are not all multiples of four, so they are word indices
package baud_pkg;
  // ***********************************
  // register indices and byte addresses
  // ***********************************
  localparam logic [7:0] idx_ext_rx_prescaler = 8'h1d;
  localparam logic [7:0] idx_ext_tx_prescaler = 8'h1e;
  localparam logic [7:0] idx_serial_status = 8'h20;
  localparam logic [7:0] idx_serial_data = 8'h21;
  localparam logic [7:0] idx_baud_rate_select = 8'h22;
  localparam logic [7:0] idx_serial_control_one = 8'h23;
  localparam logic [7:0] idx_serial_control_two = 8'h24;
  localparam logic [9:0] addr_ext_rx_prescaler = {idx_ext_rx_prescaler, 2'b00};
  localparam logic [9:0] addr_ext_tx_prescaler = {idx_ext_tx_prescaler, 2'b00};
  localparam logic [9:0] addr_serial_status = {idx_serial_status, 2'b00};
  localparam logic [9:0] addr_serial_data = {idx_serial_data, 2'b00};
  localparam logic [9:0] addr_baud_rate_select = {idx_baud_rate_select, 2'b00};
  localparam logic [9:0] addr_serial_control_one = {idx_serial_control_one, 2'b00};
  localparam logic [9:0] addr_serial_control_two = {idx_serial_control_two, 2'b00};
  // ***********************************
  // reset values
  // ***********************************
  localparam logic [7:0] rst_ext_prescaler = 8'h00;
  localparam logic [7:0] rst_serial_status = 8'hc0;
  localparam logic [7:0] rst_baud_rate_select = 8'h00;
  localparam logic [7:0] rst_serial_control = 8'h00;
  // ***********************************
  // field positions
  // ***********************************
  localparam int first_prescale_msb = 7;
  localparam int first_prescale_lsb = 6;
  localparam int tx_divisor_msb = 5;
  localparam int tx_divisor_lsb = 3;
  localparam int rx_divisor_msb = 2;
  localparam int rx_divisor_lsb = 0;
  localparam int serial_power_down_bit = 5;
  // ***********************************
  // division constants
  // ***********************************
  localparam logic [3:0] first_prescale_factor_0 = 4'h1;
  localparam logic [3:0] first_prescale_factor_1 = 4'h3;
  localparam logic [3:0] first_prescale_factor_2 = 4'h4;
  localparam logic [3:0] first_prescale_factor_3 = 4'hd;
  localparam logic [4:0] fixed_divide = 5'h10;
  // bus clock 100 MHz; tick pulses are one period wide
  localparam int clock_period_ns = 10;
  localparam logic [7:0] apb_unmapped_read = 8'h00;
endpackage

// ===== rtl/rate_divider.sv
// Purpose: divide a stream of enable pulses by a programmable count
// Assumes: en_in is a one-cycle pulse in the pclk domain
// Notes: divisor zero is treated as one; restart clears the count
`timescale 1ns/10ps
module rate_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  input wire logic en_in,
  input wire logic [7:0] divisor,
  output logic tick
);
  logic [7:0] count_ff; // pulses seen since last tick
  logic tick_ff; // registered output pulse
  logic [7:0] last_count; // terminal value of the count

  // a zero divisor would never end the count, so treat it as one
  assign last_count = (divisor == 8'h00) ? 8'h00 : divisor - 8'h01;

  // ***********************************
  // counter
  // ***********************************
  // counts input pulses and wraps at the divisor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= 8'h00;
    end else if (restart) begin
      count_ff <= 8'h00;
    end else if (en_in) begin
      if (count_ff >= last_count) begin
        count_ff <= 8'h00;
      end else begin
        count_ff <= count_ff + 8'h01;
      end
    end
  end

  // tick issued on the wrapping input pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= en_in && !restart && (count_ff >= last_count);
    end
  end

  assign tick = tick_ff;
endmodule

// ===== rtl/stage_counter.sv
// Purpose: free counter turning a pulse stream into binary taps
// Assumes: en_in is a one-cycle pulse in the pclk domain
// Notes: bit k of the count toggles every 2^k input pulses
`timescale 1ns/10ps
module stage_counter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  input wire logic en_in,
  output logic [7:0] count
);
  logic [7:0] count_ff; // running count of input pulses

  // ***********************************
  // counter
  // ***********************************
  // wraps naturally at 256, so every power-of-two tap is periodic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= 8'h00;
    end else if (restart) begin
      count_ff <= 8'h00;
    end else if (en_in) begin
      count_ff <= count_ff + 8'h01;
    end
  end

  assign count = count_ff;
endmodule

// ===== testbench/baud_asserts.sv
// Purpose: port-level checker for the baud rate generator
// Assumes: single pclk domain, presetn asynchronous active low
// Notes: bound to the top module by the bind at the foot of this file
`timescale 1ns/10ps
module baud_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic byte_busy,
  input wire logic tx_tick,
  input wire logic rx_tick,
  input wire logic data_wr_pulse,
  input wire logic [7:0] control_one,
  input wire logic halted
);
  // ***********************************
  // one clock domain, reset disables all
  // ***********************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // every setup cycle is answered in the very next cycle
  property p_ready_after_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("pready late");
  // pready only inside an access phase
  property p_ready_in_access;
    pready |-> psel && penable;
  endproperty
  a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
  // an error never stands without its answer
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
  // 8-bit registers leave the upper read bits clear
  property p_upper_zero;
    pready |-> prdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("prdata upper bits set");
  // a data write gives one pulse, not a level
  property p_wr_pulse_single;
    data_wr_pulse |=> !data_wr_pulse;
  endproperty
  a_wr_pulse_single: assert property (p_wr_pulse_single) else $error("data write pulse too long");
  // a stopped generator emits nothing
  property p_halt_no_ticks;
    halted |-> !tx_tick && !rx_tick;
  endproperty
  a_halt_no_ticks: assert property (p_halt_no_ticks) else $error("tick while halted");
  // stopping waits for the byte in flight to end
  property p_halt_blocked_busy;
    byte_busy && !halted |=> !halted;
  endproperty
  a_halt_blocked_busy: assert property (p_halt_blocked_busy) else $error("halt during byte");
  // a halt only comes from the power-down bit with no byte in flight, both seen one edge earlier
  property p_halt_cause;
    $rose(halted) |-> $past(control_one[baud_pkg::serial_power_down_bit]) && !$past(byte_busy);
  endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt without cause");
  // clearing the bit restarts the dividers promptly
  property p_halt_release;
    $fell(control_one[baud_pkg::serial_power_down_bit]) |-> ##[0:2] !halted;
  endproperty
  a_halt_release: assert property (p_halt_release) else $error("halt not released");
endmodule

bind serial_baud_rate_generator baud_asserts baud_asserts_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .byte_busy(byte_busy), .tx_tick(tx_tick), .rx_tick(rx_tick), .data_wr_pulse(data_wr_pulse),
  .control_one(control_one), .halted(halted));

// ===== testbench/test_serial_baud_rate_generator.sv
// Purpose: self-checking bench for the baud rate generator
// Assumes: apb answers within 16 cycles, ticks within 9000 cycles
// Notes: periods are measured tick to tick, never the first phase
`timescale 1ns/10ps
module test_serial_baud_rate_generator;
  typedef struct {logic [7:0] brr, etp, erp; int tx, rx;} row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, byte_busy;
  logic [31:0] paddr, pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [7:0] status_in, rx_data_in, tx_data, control_one, control_two;
  logic tx_tick, rx_tick, data_wr_pulse, halted, e;
  int bad_count = 0, comparisons = 0, pulses = 0, n, t;
  // brr, ext tx, ext rx, tx period, rx period
  row_type rows[7] = '{'{8'h00, 8'h00, 8'h00, 1, 1}, '{8'h4b, 8'h00, 8'h00, 6, 24},
    '{8'h95, 8'h00, 8'h00, 16, 128}, '{8'he6, 8'h00, 8'h00, 208, 832}, '{8'h3f, 8'h00, 8'h00, 128, 128},
    '{8'h40, 8'h02, 8'h01, 96, 48}, '{8'h01, 8'hff, 8'h00, 4080, 2}};
  serial_baud_rate_generator serial_baud_rate_generator_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .byte_busy(byte_busy), .status_in(status_in),
    .rx_data_in(rx_data_in), .tx_tick(tx_tick), .rx_tick(rx_tick), .data_wr_pulse(data_wr_pulse),
    .tx_data(tx_data), .control_one(control_one), .control_two(control_two), .halted(halted));
  // ***********************************
  // clock and pulse monitor
  // ***********************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // counts data write pulses seen at the edges
  always @(posedge pclk) begin
    if (data_wr_pulse === 1'b1) pulses++;
  end
  // ***********************************
  // compare, bus and timing tasks
  // ***********************************
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      bad_count++;
      $display("Error at %0t: count %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; idle edge first so psel never toggles twice in a step
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] s);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {22'h000000, a};
    pwdata <= {24'h000000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      bad_count++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00, 4'hf);
    chk(q, {24'h000000, exp});
  endtask
  // edges until the chosen tick is seen; bounded
  task automatic wait_tick(input bit rx, output int c);
    for (c = 1; c <= 9000; c++) begin
      @(posedge pclk);
      if ((rx ? rx_tick : tx_tick) === 1'b1) return;
    end
    bad_count++;
    tally_and_finish();
  endtask
  // ***********************************
  // main sequence
  // ***********************************
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0;
    pstrb = 4'hf; byte_busy = 1'b0; status_in = 8'hc0; rx_data_in = 8'ha5;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(baud_pkg::addr_ext_rx_prescaler, 8'h00);
    rd(baud_pkg::addr_ext_tx_prescaler, 8'h00);
    rd(baud_pkg::addr_baud_rate_select, 8'h00);
    rd(baud_pkg::addr_serial_control_two, 8'h00);
    rd(baud_pkg::addr_serial_status, 8'hc0);
    rd(baud_pkg::addr_serial_data, 8'ha5);
    // table: program, read back the ext tx factor, measure both periods
    foreach (rows[r]) begin
      wr(baud_pkg::addr_baud_rate_select, rows[r].brr);
      wr(baud_pkg::addr_ext_tx_prescaler, rows[r].etp);
      wr(baud_pkg::addr_ext_rx_prescaler, rows[r].erp);
      rd(baud_pkg::addr_ext_tx_prescaler, rows[r].etp);
      wait_tick(1'b0, n);
      wait_tick(1'b0, n);
      chk_cnt(n, rows[r].tx);
      wait_tick(1'b1, n);
      wait_tick(1'b1, n);
      chk_cnt(n, rows[r].rx);
    end
    // refused accesses: strobe off, unmapped place
    xfer(1'b1, baud_pkg::addr_baud_rate_select, 8'h77, 4'he);
    rd(baud_pkg::addr_baud_rate_select, 8'h01);
    xfer(1'b0, 10'h040, 8'h00, 4'hf);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    // serial data write reaches the transmitter once
    wr(baud_pkg::addr_serial_data, 8'h3c);
    repeat (2) @(posedge pclk);
    chk({24'h0, tx_data}, 32'h3c);
    chk_cnt(pulses, 1);
    // control two is stored, read back and passed to the serial unit
    wr(baud_pkg::addr_serial_control_two, 8'h5a);
    rd(baud_pkg::addr_serial_control_two, 8'h5a);
    chk({24'h0, control_two}, 32'h5a);
    // power down waits for the byte, then stops all ticks
    wr(baud_pkg::addr_baud_rate_select, 8'h00);
    wr(baud_pkg::addr_ext_tx_prescaler, 8'h00);
    byte_busy <= 1'b1;
    wr(baud_pkg::addr_serial_control_one, 8'h20);
    repeat (4) @(posedge pclk);
    chk({24'h0, control_one}, 32'h20);
    chk({31'h0, halted}, 32'h0);
    byte_busy <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, halted}, 32'h1);
    t = 0;
    repeat (40) begin
      @(posedge pclk);
      if (tx_tick === 1'b1 || rx_tick === 1'b1) t++;
    end
    chk_cnt(t, 0);
    wr(baud_pkg::addr_serial_control_one, 8'h00);
    wait_tick(1'b0, n);
    wait_tick(1'b0, n);
    chk_cnt(n, 1);
    chk({31'h0, halted}, 32'h0);
    // reset in mid-run clears the extended rx factor
    wr(baud_pkg::addr_ext_rx_prescaler, 8'h55);
    rd(baud_pkg::addr_ext_rx_prescaler, 8'h55);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(baud_pkg::addr_ext_rx_prescaler, 8'h00);
    tally_and_finish();
  end
endmodule
